//--- hdl/bsp_pkg.sv
// Operation
// R1: Each path runs from its first cell at data-in to its last at data-out.
// R2: Instruction path captures 001; the shifted value becomes the instruction.
// R3: Bypass is one bit, captures zero, and never touches the processor.
// R4: The main path is 141 cells long and reaches the processor pins.
// R5: Five groups, each with a pinless cell that enables its drivers.
// R6: Groups: data bus, address bus, control, memory clock, error/request.
// R7: Without bus grant, control drivers are off; error/request stay on.
// R8: Data group: enable cell, then input and output cell per bit from 0.
// R9: Own enable cells gate the address and the control drivers.
// R10: Strap high: clock-power cell 1 drives memory clock, 0 disables it.
// R11: Strap low: the memory clock driver stays off regardless of the cell.
// R12: Clock-power 1 and enabled: memory-clock cell captures and substitutes.
// R13: Clock-power 0: memory-clock cell only samples the pin.
// R14: Fifth enable gates error and request; request off in test mode.
// R15: Quick path: control in 0, 1, then status 2, 1, 0; rest normal.
// R16: Quick status cells capture and shift only; status pins stay live.
// R17: Quick shifting leaves all other shift cells undefined.
// R18: All paths share one common set of shift clocks.
// R19: Second vendor path is the main path without the memory-clock cell.
// R20: The tester shifts exactly the selected path length before updating; the bench's path-length loop shifts 8 bits more.
package bsp_pkg;

  localparam int BSP_MAIN_LEN = 141;
  localparam int BSP_ID_W = 32;
  localparam int BSP_CTRL_W = 22;
  localparam int BSP_IN_W = 12;
  localparam int BSP_PIN_W = 48;

  // Cell positions, counted from the data-in end starting at 1.
  localparam int C_DATA_EN = 1;
  localparam int C_ID_BASE = 2;
  localparam int C_ADDR_HI = 66;
  localparam int C_ADDR_EN = 96;
  localparam int C_CTRL_EN = 97;
  localparam int C_A1 = 98;
  localparam int C_A0 = 99;
  localparam int C_CTRL_LO = 100;
  localparam int C_REQ = 108;
  localparam int C_CLKPWR = 109;
  localparam int C_MCLK = 110;
  localparam int C_IN_BASE = 111;
  localparam int C_CNTL0 = 112;
  localparam int C_CNTL1 = 113;
  localparam int C_ERR_EN = 123;
  localparam int C_ERR = 124;
  localparam int C_STAT2 = 125;
  localparam int C_STAT0 = 127;
  localparam int C_CTRL_HI = 128;
  localparam int CTRL_LO_N = 8;

  // Instruction codes and capture values.
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_NOMEM = 3'h2;
  localparam logic [2:0] IR_INTEST = 3'h4;
  localparam logic [2:0] IR_SAMPLE = 3'h5;
  localparam logic [2:0] IR_QUICK = 3'h6;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic BYP_CAPTURE = 1'b0;
  localparam logic [2:0] IR_RESET = IR_BYPASS;

  typedef enum logic [1:0] {
    PATH_BYP, PATH_MAIN, PATH_QUICK, PATH_NOMEM
  } bsp_path_type;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } bsp_tap_type;

endpackage : bsp_pkg

//--- hdl/bsp_scan.sv
`timescale 1ns/1ps
module bsp_scan
  import bsp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic tck,
  input wire logic tap_rst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [31:0] id_pin_i,
  output logic [31:0] id_pin_o,
  output logic id_pin_oe,
  output logic [31:0] addr_pin_o,
  output logic addr_pin_oe,
  output logic [21:0] ctrl_pin_o,
  output logic ctrl_pin_oe,
  input wire logic [11:0] in_pin_i,
  input wire logic memory_clock_pin_i,
  output logic memory_clock_pin_o,
  output logic memory_clock_pin_oe,
  output logic memory_error_out,
  output logic memory_error_oe,
  output logic bus_request_out,
  output logic bus_request_oe,
  output logic [2:0] status_pin_o,
  input wire logic bus_grant_pin_i,
  input wire logic test_mode_pin_i,
  input wire logic clock_power_strap,
  input wire logic [31:0] core_id_o,
  input wire logic core_id_oe,
  input wire logic [31:0] core_addr_o,
  input wire logic [21:0] core_ctrl_o,
  input wire logic core_mclk_o,
  input wire logic core_error_o,
  input wire logic core_request_o,
  input wire logic [2:0] core_status_o,
  output logic [31:0] core_id_i,
  output logic [11:0] core_in_i,
  output logic core_mclk_i
);

  // Pin inputs pass two flip-flops in the core clock domain.
  logic [BSP_PIN_W-1:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= {id_pin_i, in_pin_i, memory_clock_pin_i, bus_grant_pin_i,
                   test_mode_pin_i, clock_power_strap};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic [31:0] id_s;
  logic [11:0] in_s;
  logic mclk_s, grant_s, testm_s, strap_s;
  assign {id_s, in_s, mclk_s, grant_s, testm_s, strap_s} = pin_s2_q;

  // Test-clock domain: controller, instruction, shift and hold stages.
  bsp_tap_type st_q, st_d;
  logic [2:0] ir_sh_q, test_instruction_reg;
  logic byp_q;
  logic [BSP_MAIN_LEN:1] shift_stage, sh_d;
  logic [BSP_MAIN_LEN:1] parallel_hold_stage, hold_d;
  logic [BSP_MAIN_LEN:1] cap_q, cap_t1_q, cap_t2_q;
  bsp_path_type path;

  // Decode of the held instruction into the selected data path.
  always_comb
  begin
    case (test_instruction_reg)
      IR_EXTEST, IR_INTEST, IR_SAMPLE: path = PATH_MAIN;
      IR_QUICK: path = PATH_QUICK;
      IR_NOMEM: path = PATH_NOMEM;
      default: path = PATH_BYP;
    endcase
  end

  // Standard test-port controller walk.
  always_comb
  begin
    case (st_q)
      TLR: st_d = tms ? TLR : RTI;
      RTI: st_d = tms ? SEL_DR : RTI;
      SEL_DR: st_d = tms ? SEL_IR : CAP_DR;
      CAP_DR: st_d = tms ? EX1_DR : SH_DR;
      SH_DR: st_d = tms ? EX1_DR : SH_DR;
      EX1_DR: st_d = tms ? UPD_DR : PA_DR;
      PA_DR: st_d = tms ? EX2_DR : PA_DR;
      EX2_DR: st_d = tms ? UPD_DR : SH_DR;
      UPD_DR: st_d = tms ? SEL_DR : RTI;
      SEL_IR: st_d = tms ? TLR : CAP_IR;
      CAP_IR: st_d = tms ? EX1_IR : SH_IR;
      SH_IR: st_d = tms ? EX1_IR : SH_IR;
      EX1_IR: st_d = tms ? UPD_IR : PA_IR;
      PA_IR: st_d = tms ? EX2_IR : PA_IR;
      EX2_IR: st_d = tms ? UPD_IR : SH_IR;
      UPD_IR: st_d = tms ? SEL_DR : RTI;
      default: st_d = TLR;
    endcase
  end

  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      st_q <= TLR;
    else
      st_q <= st_d;
  end

  // Instruction path: fixed capture, shifted value becomes the instruction.
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      ir_sh_q <= IR_CAPTURE;
      test_instruction_reg <= IR_RESET;
    end
    else
    begin
      if (st_q == CAP_IR)
        ir_sh_q <= IR_CAPTURE; // R2
      else if (st_q == SH_IR)
        ir_sh_q <= {tdi, ir_sh_q[2:1]}; // R1
      if (st_q == TLR)
        test_instruction_reg <= IR_RESET;
      else if (st_q == UPD_IR)
        test_instruction_reg <= ir_sh_q; // R2
    end
  end

  // Bypass bit: captures zero, feeds nothing into the processor.
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      byp_q <= BYP_CAPTURE;
    else if (st_q == CAP_DR)
      byp_q <= BYP_CAPTURE; // R3
    else if (st_q == SH_DR)
      byp_q <= tdi;
  end

  // Next shift value: every cell moves on the one shared shift clock, so a
  // quick-path shift scrambles the other cells too.
  always_comb
  begin
    sh_d = {shift_stage[BSP_MAIN_LEN-1:1], tdi}; // R1 R4 R18 R17
    if (path == PATH_NOMEM)
      sh_d[C_IN_BASE] = shift_stage[C_CLKPWR]; // R19
    if (path == PATH_QUICK)
    begin
      sh_d[C_CNTL0] = tdi; // R15
      sh_d[C_STAT2] = shift_stage[C_CNTL1]; // R15
    end
  end

  // Capture on entering the data scan, shift while scanning.
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      shift_stage <= '0;
    else if (path != PATH_BYP && st_q == CAP_DR)
      shift_stage <= cap_t2_q;
    else if (path != PATH_BYP && st_q == SH_DR)
      shift_stage <= sh_d;
  end

  // Update: quick path touches only the control-input cells.
  always_comb
  begin
    hold_d = parallel_hold_stage;
    if (path == PATH_MAIN)
      hold_d = shift_stage;
    else if (path == PATH_NOMEM)
    begin
      hold_d = shift_stage;
      hold_d[C_MCLK] = parallel_hold_stage[C_MCLK]; // R19
    end
    else if (path == PATH_QUICK)
    begin
      hold_d[C_CNTL0] = shift_stage[C_CNTL0]; // R15
      hold_d[C_CNTL1] = shift_stage[C_CNTL1]; // R15
    end
  end

  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      parallel_hold_stage <= '0;
    else if (st_q == UPD_DR)
      parallel_hold_stage <= hold_d;
  end

  // Captured pin picture crosses into the test clock through two stages.
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      cap_t1_q <= '0;
      cap_t2_q <= '0;
    end
    else
    begin
      cap_t1_q <= cap_q;
      cap_t2_q <= cap_t1_q;
    end
  end

  // Serial output changes on the falling test clock, driven while shifting.
  always_ff @(negedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo_oe <= (st_q == SH_DR) || (st_q == SH_IR);
      if (st_q == SH_IR)
        tdo <= ir_sh_q[0];
      else if (path == PATH_BYP)
        tdo <= byp_q;
      else if (path == PATH_QUICK)
        tdo <= shift_stage[C_STAT0]; // R15
      else
        tdo <= shift_stage[BSP_MAIN_LEN]; // R1
    end
  end

  // A toggle marks each change of the hold stage or the instruction. The
  // words then stay still for many core clocks, so the core side copies
  // them whole after the synchronised toggle moves, never bit by bit.
  logic xfer_tgl_q;
  always_ff @(posedge tck or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      xfer_tgl_q <= 1'h0;
    else if (st_q == UPD_DR || st_q == UPD_IR || st_q == TLR)
      xfer_tgl_q <= !xfer_tgl_q;
  end

  // Core side: two stages for the toggle, a third to find its edge. A core
  // reset leaves bypass in force until the next update reaches it.
  logic [2:0] xfer_s_q;
  logic [BSP_MAIN_LEN:1] hs;
  logic [2:0] md;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      xfer_s_q <= '0;
    else
      xfer_s_q <= {xfer_s_q[1:0], xfer_tgl_q};
  end

  // Whole-word copy of the settled hold stage and instruction.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hs <= '0;
      md <= IR_RESET;
    end
    else if (xfer_s_q[2] != xfer_s_q[1])
    begin
      hs <= parallel_hold_stage;
      md <= test_instruction_reg;
    end
  end

  logic drive, with_mclk, quick;
  assign drive = (md == IR_EXTEST) || (md == IR_INTEST) || (md == IR_NOMEM);
  assign with_mclk = (md == IR_EXTEST) || (md == IR_INTEST);
  assign quick = (md == IR_QUICK);

  // Per-cell mapping of pins to the capture picture and the hold stage.
  logic [BSP_MAIN_LEN:1] cap_w;
  logic [31:0] h_id_in, h_id_out, h_addr;
  logic [21:0] h_ctrl;
  logic [11:0] h_in;
  genvar k;
  generate
    for (k = 0; k < BSP_ID_W; k++)
    begin : g_id
      assign cap_w[C_ID_BASE+2*k] = id_s[k]; // R8
      assign cap_w[C_ID_BASE+2*k+1] = core_id_o[k]; // R8
      assign h_id_in[k] = hs[C_ID_BASE+2*k];
      assign h_id_out[k] = hs[C_ID_BASE+2*k+1];
    end
    for (k = 2; k < BSP_ID_W; k++)
    begin : g_addr
      assign cap_w[C_ADDR_HI+31-k] = core_addr_o[k]; // R6
      assign h_addr[k] = hs[C_ADDR_HI+31-k];
    end
    for (k = 0; k < BSP_CTRL_W; k++)
    begin : g_ctrl
      localparam int P = (k < CTRL_LO_N) ? C_CTRL_LO + k
                                         : C_CTRL_HI + k - CTRL_LO_N;
      assign cap_w[P] = core_ctrl_o[k];
      assign h_ctrl[k] = hs[P];
    end
    for (k = 0; k < BSP_IN_W; k++)
    begin : g_in
      assign cap_w[C_IN_BASE+k] = in_s[k];
      assign h_in[k] = hs[C_IN_BASE+k];
    end
    for (k = 0; k < 3; k++)
    begin : g_stat
      assign cap_w[C_STAT0-k] = core_status_o[k]; // R16
    end
  endgenerate
  assign cap_w[C_A1] = core_addr_o[1];
  assign cap_w[C_A0] = core_addr_o[0];
  assign h_addr[1] = hs[C_A1];
  assign h_addr[0] = hs[C_A0];
  assign cap_w[C_DATA_EN] = hs[C_DATA_EN];
  assign cap_w[C_ADDR_EN] = hs[C_ADDR_EN];
  assign cap_w[C_CTRL_EN] = hs[C_CTRL_EN];
  assign cap_w[C_ERR_EN] = hs[C_ERR_EN];
  assign cap_w[C_CLKPWR] = hs[C_CLKPWR];
  assign cap_w[C_REQ] = core_request_o;
  assign cap_w[C_ERR] = core_error_o;
  // Memory-clock cell: internal clock when the clock-power cell and the strap are high, else the pin level.
  assign cap_w[C_MCLK] = (hs[C_CLKPWR] && strap_s) ? core_mclk_o
                                                  : mclk_s; // R12 R13

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cap_q <= '0;
    else
      cap_q <= cap_w;
  end

  // Pin drivers: hold stage in drive modes, processor otherwise, with address and control enabled by grant.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      id_pin_o <= '0;
      id_pin_oe <= 1'b0;
      addr_pin_o <= '0;
      addr_pin_oe <= 1'b0;
      ctrl_pin_o <= '0;
      ctrl_pin_oe <= 1'b0;
      status_pin_o <= '0;
    end
    else
    begin
      id_pin_o <= drive ? h_id_out : core_id_o;
      id_pin_oe <= drive ? hs[C_DATA_EN] : core_id_oe; // R5
      addr_pin_o <= drive ? h_addr : core_addr_o;
      addr_pin_oe <= drive ? hs[C_ADDR_EN] : grant_s; // R9
      ctrl_pin_o <= drive ? h_ctrl : core_ctrl_o;
      ctrl_pin_oe <= drive ? hs[C_CTRL_EN] : grant_s; // R9 R7
      status_pin_o <= drive ? {hs[C_STAT2], hs[C_STAT2+1], hs[C_STAT0]}
                            : core_status_o; // R16
    end
  end

  // Error and request group stays enabled without grant; request is held
  // off whenever the test-mode input is active.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      memory_error_out <= 1'b0;
      memory_error_oe <= 1'b0;
      bus_request_out <= 1'b0;
      bus_request_oe <= 1'b0;
    end
    else
    begin
      memory_error_out <= drive ? hs[C_ERR] : core_error_o;
      memory_error_oe <= drive ? hs[C_ERR_EN] : 1'b1; // R7 R14
      bus_request_out <= drive ? hs[C_REQ] : core_request_o;
      bus_request_oe <= (drive ? hs[C_ERR_EN] : 1'b1) && !testm_s; // R14
    end
  end

  // Memory clock: the strap gates the driver; the cell enables it in external and internal test.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      memory_clock_pin_o <= 1'b0;
      memory_clock_pin_oe <= 1'b0;
      core_mclk_i <= 1'b0;
    end
    else
    begin
      memory_clock_pin_oe <= strap_s
                             && (!with_mclk || hs[C_CLKPWR]); // R10 R11
      memory_clock_pin_o <= (with_mclk && hs[C_CLKPWR]) ? hs[C_MCLK]
                                                      : core_mclk_o; // R12
      core_mclk_i <= mclk_s; // R13
    end
  end

  // Internal inputs: hold stage in drive modes, control inputs only in the
  // quick mode, pins otherwise.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      core_id_i <= '0;
      core_in_i <= '0;
    end
    else
    begin
      core_id_i <= drive ? h_id_in : id_s;
      core_in_i <= drive ? h_in : in_s;
      if (quick)
      begin
        core_in_i[C_CNTL0-C_IN_BASE] <= h_in[C_CNTL0-C_IN_BASE]; // R15
        core_in_i[C_CNTL1-C_IN_BASE] <= h_in[C_CNTL1-C_IN_BASE]; // R15
      end
    end
  end

  ir_capture_a: assert property (@(posedge tck) disable iff (!tap_rst_n)
    st_q == CAP_IR |=> ir_sh_q == 3'h1) else $error("ir capture"); // R2
  byp_capture_a: assert property (@(posedge tck) disable iff (!tap_rst_n)
    st_q == CAP_DR |=> byp_q == 1'b0) else $error("bypass capture"); // R3
  main_order_a: assert property (@(posedge tck) disable iff (!tap_rst_n)
    st_q == SH_DR && path == PATH_MAIN |=> shift_stage[1] == $past(tdi)
    && shift_stage[141] == $past(shift_stage[140]))
    else $error("main order"); // R1
  quick_order_a: assert property (@(posedge tck) disable iff (!tap_rst_n)
    st_q == SH_DR && path == PATH_QUICK |=> shift_stage[125] ==
    $past(shift_stage[113]) && shift_stage[112] == $past(tdi))
    else $error("quick order"); // R15
  nomem_skip_a: assert property (@(posedge tck) disable iff (!tap_rst_n)
    st_q == SH_DR && path == PATH_NOMEM |=> shift_stage[111] ==
    $past(shift_stage[109])) else $error("clock cell not skipped"); // R19
  status_live_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    quick |=> status_pin_o == $past(core_status_o))
    else $error("status overridden"); // R16
  strap_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !strap_s |=> !memory_clock_pin_oe) else $error("clock driven"); // R11
  req_test_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    testm_s |=> !bus_request_oe) else $error("request in test"); // R14
  grant_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !drive && !grant_s |=> !ctrl_pin_oe && memory_error_oe)
    else $error("grant gating"); // R7
  clkpwr_on_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    with_mclk && strap_s && hs[C_CLKPWR] |=> memory_clock_pin_oe)
    else $error("memory clock not enabled"); // R10

  ir_update_c: cover property (@(posedge tck) disable iff (!tap_rst_n)
    st_q == UPD_IR);
  main_update_c: cover property (@(posedge tck) disable iff (!tap_rst_n)
    st_q == UPD_DR && path == PATH_MAIN);
  quick_shift_c: cover property (@(posedge tck) disable iff (!tap_rst_n)
    st_q == SH_DR && path == PATH_QUICK);
  extest_drive_c: cover property (@(posedge ref_clk) disable iff (!rstn)
    drive && id_pin_oe);

endmodule : bsp_scan

//--- sim/bsp_tester_model.sv
`timescale 1ns/1ps
// Board tester model that drives the serial test link with its own clock.
module bsp_tester_model
  import bsp_pkg::*;
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // The link clock stands low between frames.
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One link clock: lines change after the fall, data-out is read at the rise.
  task automatic tick(input logic m, input logic b, output logic s);
    tms = m;
    tdi = b;
    #24;
    s = tdo;
    tck = 1'b1;
    #24;
    tck = 1'b0;
  endtask : tick

  // Five clocks with mode select high, then park in run-test/idle.
  task automatic tap_reset();
    logic s;
    repeat (5) tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
  endtask : tap_reset

  // Whole frame; the cell nearest data-out leaves first and din[k-1] fills
  // cell k. A few idle clocks first let the capture picture settle.
  task automatic shift(input logic ir, input int n, input logic [159:0] din,
                       output logic [159:0] dout);
    logic s;
    dout = '0;
    repeat (3) tick(1'b0, tdi, s);
    tick(1'b1, tdi, s);
    if (ir)
      tick(1'b1, tdi, s);
    tick(1'b0, tdi, s);
    tick(1'b0, tdi, s);
    for (int j = 0; j < n; j++)
    begin
      tick(j == n - 1, din[n-1-j], s);
      dout[n-1-j] = s;
    end
    tick(1'b1, ~din[0], s);
    tick(1'b0, din[0], s);
  endtask : shift
endmodule : bsp_tester_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the scan path block.
module tb_top
  import bsp_pkg::*;
;
  logic ref_clk, rstn, tap_rst_n, tck, tms, tdi, tdo, tdo_oe;
  logic [31:0] id_pin_i, id_pin_o, addr_pin_o, core_id_o, core_addr_o;
  logic [31:0] core_id_i, d;
  logic id_pin_oe, addr_pin_oe, ctrl_pin_oe, memory_clock_pin_i;
  logic memory_clock_pin_o, memory_clock_pin_oe, memory_error_out;
  logic memory_error_oe, bus_request_out, bus_request_oe, bus_grant_pin_i;
  logic test_mode_pin_i, clock_power_strap, core_id_oe, core_mclk_o;
  logic core_error_o, core_request_o, core_mclk_i;
  logic [21:0] ctrl_pin_o, core_ctrl_o;
  logic [11:0] in_pin_i, core_in_i;
  logic [2:0] status_pin_o, core_status_o;
  logic [159:0] q, v, pat;
  logic [2:0] codes [6];
  int lens [6];
  int err_count, n_tests;

  bsp_scan dut (.ref_clk, .rstn, .tck, .tap_rst_n, .tms, .tdi, .tdo, .tdo_oe,
    .id_pin_i, .id_pin_o, .id_pin_oe, .addr_pin_o, .addr_pin_oe, .ctrl_pin_o,
    .ctrl_pin_oe, .in_pin_i, .memory_clock_pin_i, .memory_clock_pin_o,
    .memory_clock_pin_oe, .memory_error_out, .memory_error_oe,
    .bus_request_out, .bus_request_oe, .status_pin_o, .bus_grant_pin_i,
    .test_mode_pin_i, .clock_power_strap, .core_id_o, .core_id_oe,
    .core_addr_o, .core_ctrl_o, .core_mclk_o, .core_error_o,
    .core_request_o, .core_status_o, .core_id_i, .core_in_i, .core_mclk_i);

  bsp_tester_model tester (.tck, .tms, .tdi, .tdo);

  // Core clock at 200 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // Cell number of an address bit and of a control bit.
  function automatic int acell(int b);
    return b >= 2 ? C_ADDR_HI + 31 - b : (b == 1 ? C_A1 : C_A0);
  endfunction : acell

  function automatic int ccell(int b);
    return b < CTRL_LO_N ? C_CTRL_LO + b : C_CTRL_HI + b - CTRL_LO_N;
  endfunction : ccell

  // Builds a main-path image: enables, clock-power, and pin values from x.
  function automatic logic [159:0] hold_vec(input logic [4:0] en,
                                            input logic pwr,
                                            input logic [31:0] x);
    logic [159:0] r;
    r = '0;
    r[C_DATA_EN-1] = en[0];
    r[C_ADDR_EN-1] = en[1];
    r[C_CTRL_EN-1] = en[2];
    r[C_ERR_EN-1] = en[4];
    r[C_CLKPWR-1] = pwr;
    r[C_MCLK-1] = x[0];
    r[C_ERR-1] = x[1];
    r[C_REQ-1] = x[2];
    for (int b = 0; b < 32; b++)
    begin
      r[C_ID_BASE-1+2*b] = ~x[b];
      r[C_ID_BASE+2*b] = x[b];
      r[acell(b)-1] = ~x[b];
    end
    for (int b = 0; b < 22; b++)
      r[ccell(b)-1] = x[b];
    for (int b = 0; b < 12; b++)
      r[C_IN_BASE+b-1] = x[b+4];
    return r;
  endfunction : hold_vec

  // Loads an instruction, checks its capture, then scans a data path.
  task automatic run(input logic [2:0] code, input int n,
                     input logic [159:0] din, output logic [159:0] dout);
    logic [159:0] irv;
    logic [159:0] cap;
    irv = '0;
    irv[2:0] = {code[0], code[1], code[2]};
    tester.shift(1'b1, 3, irv, cap);
    check(cap[2:0], {IR_CAPTURE[0], IR_CAPTURE[1], IR_CAPTURE[2]});
    tester.shift(1'b0, n, din, dout);
    repeat (4) @(negedge ref_clk);
  endtask : run

  // Waits for level inputs to pass their synchronisers.
  task automatic settle();
    repeat (4) @(negedge ref_clk);
  endtask : settle

  // Cuts a hung run short.
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end

  // Main sequence.
  initial
  begin
    err_count = 0;
    n_tests = 0;
    rstn = 1'b0;
    tap_rst_n = 1'b0;
    id_pin_i = 32'h0f1e_2d3c;
    core_id_o = 32'h89ab_cdef;
    core_addr_o = 32'h1234_5678;
    core_ctrl_o = 22'h2a_5c3e;
    in_pin_i = 12'ha5c;
    core_status_o = 3'h5;
    {bus_grant_pin_i, clock_power_strap, core_id_oe} = 3'h7;
    {test_mode_pin_i, memory_clock_pin_i} = 2'h0;
    {core_mclk_o, core_error_o, core_request_o} = 3'h7;
    codes = '{IR_SAMPLE, IR_QUICK, IR_NOMEM, IR_BYPASS, 3'h1, 3'h3};
    lens = '{141, 5, 140, 1, 1, 1};
    pat = {5{32'h9e37_79b9}};
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    tap_rst_n = 1'b1;
    settle();
    check(tdo_oe, 1'b0);
    check({addr_pin_oe, ctrl_pin_oe, memory_error_oe}, 3'h7);
    check(addr_pin_o, core_addr_o);
    bus_grant_pin_i = 1'b0;
    settle();
    check({ctrl_pin_oe, memory_error_oe, bus_request_oe}, 3'h3);
    test_mode_pin_i = 1'b1;
    settle();
    check({memory_error_oe, bus_request_oe}, 2'h2);
    {test_mode_pin_i, bus_grant_pin_i} = 2'h1;
    tester.tap_reset();
    // Path lengths for sample, quick, second vendor and bypass codes, reserved codes acting as bypass.
    for (int i = 0; i < 6; i++)
    begin
      run(codes[i], lens[i] + 8, pat, q);
      check(q[7:0], pat[lens[i]+7 -: 8]);
    end
    run(IR_BYPASS, 1, '1, q);
    check(q[0], BYP_CAPTURE);
    check(addr_pin_o, core_addr_o);
    // Sample captures pins and internal outputs in the documented cells.
    run(IR_SAMPLE, 141, '0, q);
    for (int b = 0; b < 32; b++)
    begin
      d[b] = q[acell(b)-1];
      check({q[C_ID_BASE-1+2*b], q[C_ID_BASE+2*b]},
            {id_pin_i[b], core_id_o[b]});
    end
    check(d, core_addr_o);
    check({q[C_STAT2-1], q[C_STAT2], q[C_STAT0-1]}, core_status_o);
    // External test with every group enabled and the clock driven.
    d = 32'hc3a5_96f7;
    run(IR_EXTEST, 141, hold_vec(5'h1f, 1'b1, d), q);
    check({id_pin_o, id_pin_oe, core_id_i}, {d, 1'b1, ~d});
    check({addr_pin_o, addr_pin_oe, ctrl_pin_oe}, {~d, 2'h3});
    check(ctrl_pin_o, d[21:0]);
    check(core_in_i, d[15:4]);
    check({memory_clock_pin_oe, memory_clock_pin_o}, 2'h3);
    check({memory_error_out, memory_error_oe}, 2'h3);
    check({bus_request_out, bus_request_oe}, 2'h3);
    test_mode_pin_i = 1'b1;
    clock_power_strap = 1'b0;
    settle();
    check({memory_error_oe, bus_request_oe}, 2'h2);
    check(memory_clock_pin_oe, 1'b0);
    {test_mode_pin_i, clock_power_strap} = 2'h1;
    // Only control and error groups enabled, clock-power cell cleared.
    d = 32'h3c5a_6908;
    core_mclk_o = 1'b0;
    run(IR_EXTEST, 141, hold_vec(5'h14, 1'b0, d), q);
    check(q[C_MCLK-1], core_mclk_o);
    check(q[C_DATA_EN-1], 1'b1);
    check({id_pin_oe, addr_pin_oe, ctrl_pin_oe}, 3'h1);
    check({memory_clock_pin_oe, memory_error_out}, 2'h0);
    memory_clock_pin_i = 1'b1;
    run(IR_EXTEST, 141, hold_vec(5'h14, 1'b0, d), q);
    check({q[C_MCLK-1], core_mclk_i}, 2'h3);
    // Quick path drives the control inputs only; status pins stay live.
    run(IR_QUICK, 5, 160'h09, q);
    check(q[1:0], {in_pin_i[2], in_pin_i[1]});
    check({q[2], q[3], q[4]}, core_status_o);
    check({core_in_i[2:0]}, {2'h1, in_pin_i[0]});
    check(status_pin_o, core_status_o);
    check({addr_pin_o, addr_pin_oe}, {core_addr_o, 1'b1});
    // The second vendor path skips the memory-clock cell.
    d = 32'h5b1e_c02d;
    v = hold_vec(5'h1f, 1'b1, d);
    for (int k = C_MCLK - 1; k < 159; k++)
      v[k] = v[k+1];
    run(IR_NOMEM, 140, v, q);
    check({ctrl_pin_o, memory_error_out}, {d[21:0], d[1]});
    check(id_pin_o, d);
    complete_run();
  end
endmodule : tb_top
